// [pkg/exec_pkg.sv]
package exec_pkg;
   // Register byte offsets on the APB side
   localparam logic [11:0] EVENT_STATUS_OFS = 12'h000;
   localparam logic [11:0] EVENT_MASK_OFS = 12'h004;
   localparam logic [11:0] STANDBY_CTRL_OFS = 12'h008;
   localparam logic [11:0] CORE_STATE_OFS = 12'h00C;

   // Event bit positions, shared by status and mask
   localparam int EV_SLEEP_ENTER = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_ILLEGAL = 2;
   localparam int EV_SLOT_ILLEGAL = 3;
   localparam int EV_COUNT = 4;

   // Reset values
   localparam logic [EV_COUNT-1:0] EVENT_MASK_RST = 4'h0;
   localparam logic STANDBY_CTRL_RST = 1'b0;

   // Opcodes, don't-care bits as ?
   localparam logic [15:0] OP_SHR2 = 16'b0100????00001001;
   localparam logic [15:0] OP_SHR8 = 16'b0100????00011001;
   localparam logic [15:0] OP_SHR16 = 16'b0100????00101001;
   localparam logic [15:0] OP_SLEEP = 16'h001B;
   localparam logic [15:0] OP_CP_GBR = 16'b0000????00010010;
   localparam logic [15:0] OP_CP_VBR = 16'b0000????00100010;
   localparam logic [15:0] OP_CP_SSR = 16'b0000????00110010;
   localparam logic [15:0] OP_CP_SPC = 16'b0000????01000010;
   localparam logic [15:0] OP_CP_SGR = 16'b0000????00111010;
   localparam logic [15:0] OP_CP_DBR = 16'b0000????11111010;
   localparam logic [15:0] OP_CP_BANK = 16'b0000????1???0010;
   localparam logic [15:0] OP_PU_GBR = 16'b0100????00010011;
   localparam logic [15:0] OP_PU_VBR = 16'b0100????00100011;
   localparam logic [15:0] OP_PU_SSR = 16'b0100????00110011;
   localparam logic [15:0] OP_PU_SPC = 16'b0100????01000011;
   localparam logic [15:0] OP_PU_SGR = 16'b0100????00110010;
   localparam logic [15:0] OP_PU_DBR = 16'b0100????11110010;
   localparam logic [15:0] OP_PU_BANK = 16'b0100????1???0011;

   localparam logic [31:0] PUSH_STEP = 32'h0000_0004;
   localparam logic [2:0] PC_STEP = 3'h2;

   typedef enum logic [1:0] {
      RUNNING = 2'b01,
      POWER_DOWN = 2'b10
   } core_mode_t;

   // Instruction offered by the decode stage
   typedef struct packed {
      logic valid;
      logic [15:0] opcode;
      logic in_delay_slot;
      logic privileged;
   } decode_req_t;

   // Control registers visible to the store forms
   typedef struct packed {
      logic [31:0] global_base_reg;
      logic [31:0] vector_base_reg;
      logic [31:0] saved_status_reg;
      logic [31:0] saved_pc_reg;
      logic [31:0] saved_stack_reg;
      logic [31:0] debug_base_reg;
   } ctrl_regs_t;

   // Banked register read select
   typedef struct packed {
      logic bank;
      logic [2:0] index;
   } bank_sel_t;

   // Registered execution result
   typedef struct packed {
      logic gpr_we;
      logic [3:0] gpr_idx;
      logic [31:0] gpr_data;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_data;
      logic pc_advance;
      logic illegal;
      logic slot_illegal;
   } exec_result_t;
endpackage

// [hw/shift_sleep_ctrlreg_store_exec.sv]
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1 - Logical right shift by 2, 8, 16
// RQ2 - Decode shift opcodes, one cycle, T kept
// RQ3 - Decode power-down opcode, enter power-down
// RQ4 - Power-down holds state, stops issue, waits
// RQ5 - Interrupt request ends power-down, resumes
// RQ6 - Power-down in user mode raises illegal
// RQ7 - Standby control picks sleep or standby
// RQ8 - Power-down in delay slot: slot illegal
// RQ9 - Store copies exactly one control source
// RQ10 - Decode global, vector, saved-status copies
// RQ11 - Decode saved-pc, saved-stack, debug-base copies
// RQ12 - Banked copy index in bits 6..4
// RQ13 - Push: decrement by 4, store long
// RQ14 - Decode saved-pc, saved-stack, debug-base pushes
// RQ15 - Banked push index in bits 6..4
// RQ16 - Bank select 1 uses bank 0
// RQ17 - Privileged stores in user mode: illegal
// RQ18 - Success advances PC by 2, T kept
module shift_sleep_ctrlreg_store_exec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire exec_pkg::decode_req_t instr,
   output logic instr_ready,
   input wire logic [31:0] dest_gpr_value,
   output logic [3:0] dest_gpr_rd_idx,
   input wire exec_pkg::ctrl_regs_t ctrl_regs,
   input wire logic bank_select_bit,
   output exec_pkg::bank_sel_t banked_sel,
   input wire logic [31:0] banked_gpr,
   input wire logic irq_request,
   output exec_pkg::exec_result_t result,
   output logic power_down,
   output logic standby,
   output logic irq
);
   import exec_pkg::*;

   typedef struct packed {
      core_mode_t mode;
      logic standby_latched;
      exec_result_t res;
      logic [EV_COUNT-1:0] status;
      logic [EV_COUNT-1:0] mask;
      logic standby_control_reg;
      logic [31:0] rdata;
   } state_t;

   state_t cur;
   state_t next_cur;

   logic take;
   logic is_shift;
   logic is_copy;
   logic is_push;
   logic is_sleep;
   logic needs_priv;
   logic [31:0] src_data;
   logic [31:0] shifted;
   logic [31:0] dec_addr;
   logic [EV_COUNT-1:0] ev;
   logic apb_setup;
   logic apb_wr;
   logic mapped;

   // Operand fetch: destination index always sits in bits 11..8
   assign dest_gpr_rd_idx = instr.opcode[11:8];
   // RQ16 bank inversion
   assign banked_sel.bank = ~bank_select_bit;
   // RQ12 RQ15 bank index
   assign banked_sel.index = instr.opcode[6:4];

   // RQ4 stop issue while powered down
   assign instr_ready = (cur.mode == RUNNING);
   assign take = instr.valid && instr_ready;
   assign dec_addr = dest_gpr_value - PUSH_STEP;

   // Instruction classification and source selection
   always_comb begin
      is_shift = 1'b0;
      is_copy = 1'b0;
      is_push = 1'b0;
      is_sleep = 1'b0;
      needs_priv = 1'b1;
      src_data = 32'h0000_0000;
      shifted = 32'h0000_0000;
      // RQ9 one source per form
      casez (instr.opcode)
         // RQ1 RQ2 zero-fill right shifts
         OP_SHR2: begin
            is_shift = 1'b1;
            needs_priv = 1'b0;
            shifted = dest_gpr_value >> 2;
         end
         OP_SHR8: begin
            is_shift = 1'b1;
            needs_priv = 1'b0;
            shifted = dest_gpr_value >> 8;
         end
         OP_SHR16: begin
            is_shift = 1'b1;
            needs_priv = 1'b0;
            shifted = dest_gpr_value >> 16;
         end
         // RQ3 power-down opcode
         OP_SLEEP: begin
            is_sleep = 1'b1;
         end
         // RQ10 RQ17 global base is the unprivileged one
         OP_CP_GBR: begin
            is_copy = 1'b1;
            needs_priv = 1'b0;
            src_data = ctrl_regs.global_base_reg;
         end
         OP_CP_VBR: begin
            is_copy = 1'b1;
            src_data = ctrl_regs.vector_base_reg;
         end
         OP_CP_SSR: begin
            is_copy = 1'b1;
            src_data = ctrl_regs.saved_status_reg;
         end
         // RQ11 remaining copy forms
         OP_CP_SPC: begin
            is_copy = 1'b1;
            src_data = ctrl_regs.saved_pc_reg;
         end
         OP_CP_SGR: begin
            is_copy = 1'b1;
            src_data = ctrl_regs.saved_stack_reg;
         end
         OP_CP_DBR: begin
            is_copy = 1'b1;
            src_data = ctrl_regs.debug_base_reg;
         end
         // RQ12 banked copy
         OP_CP_BANK: begin
            is_copy = 1'b1;
            src_data = banked_gpr;
         end
         // RQ13 pushes of the first three sources
         OP_PU_GBR: begin
            is_push = 1'b1;
            needs_priv = 1'b0;
            src_data = ctrl_regs.global_base_reg;
         end
         OP_PU_VBR: begin
            is_push = 1'b1;
            src_data = ctrl_regs.vector_base_reg;
         end
         OP_PU_SSR: begin
            is_push = 1'b1;
            src_data = ctrl_regs.saved_status_reg;
         end
         // RQ14 remaining pushes
         OP_PU_SPC: begin
            is_push = 1'b1;
            src_data = ctrl_regs.saved_pc_reg;
         end
         OP_PU_SGR: begin
            is_push = 1'b1;
            src_data = ctrl_regs.saved_stack_reg;
         end
         OP_PU_DBR: begin
            is_push = 1'b1;
            src_data = ctrl_regs.debug_base_reg;
         end
         // RQ15 banked push
         OP_PU_BANK: begin
            is_push = 1'b1;
            src_data = banked_gpr;
         end
         default: begin
            needs_priv = 1'b0;
         end
      endcase
   end

   // APB decode; slave answers with no wait state
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite;
   assign mapped = (paddr == EVENT_STATUS_OFS) || (paddr == EVENT_MASK_OFS) ||
                   (paddr == STANDBY_CTRL_OFS) || (paddr == CORE_STATE_OFS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Next state: execution, power-down and register file
   always_comb begin
      next_cur = cur;
      ev = '0;
      next_cur.res.gpr_we = 1'b0;
      next_cur.res.mem_we = 1'b0;
      next_cur.res.pc_advance = 1'b0;
      next_cur.res.illegal = 1'b0;
      next_cur.res.slot_illegal = 1'b0;
      case (cur.mode)
         RUNNING: begin
            if (take) begin
               next_cur.res.gpr_idx = instr.opcode[11:8];
               if (is_sleep && instr.in_delay_slot) begin
                  // RQ8 slot check ranks above privilege
                  next_cur.res.slot_illegal = 1'b1;
                  ev[EV_SLOT_ILLEGAL] = 1'b1;
               end else if (needs_priv && !instr.privileged) begin
                  // RQ6 RQ17 trap with no register or memory update
                  next_cur.res.illegal = 1'b1;
                  ev[EV_ILLEGAL] = 1'b1;
               end else if (is_sleep) begin
                  // RQ3 RQ7 enter power-down, kind from standby control
                  next_cur.mode = POWER_DOWN;
                  next_cur.standby_latched = cur.standby_control_reg;
                  ev[EV_SLEEP_ENTER] = 1'b1;
               end else if (is_shift || is_copy) begin
                  // RQ18 result and PC step, T untouched
                  next_cur.res.gpr_we = 1'b1;
                  next_cur.res.gpr_data = is_shift ? shifted : src_data;
                  next_cur.res.pc_advance = 1'b1;
               end else if (is_push) begin
                  // RQ13 write back decremented pointer, store long there
                  next_cur.res.gpr_we = 1'b1;
                  next_cur.res.gpr_data = dec_addr;
                  next_cur.res.mem_we = 1'b1;
                  next_cur.res.mem_addr = dec_addr;
                  next_cur.res.mem_data = src_data;
                  next_cur.res.pc_advance = 1'b1;
               end
            end
         end
         POWER_DOWN: begin
            // RQ5 interrupt wakes; PC steps past the sleep
            if (irq_request) begin
               next_cur.mode = RUNNING;
               next_cur.standby_latched = 1'b0;
               next_cur.res.pc_advance = 1'b1;
               ev[EV_WAKE] = 1'b1;
            end
         end
         default: begin
            next_cur.mode = RUNNING;
         end
      endcase

      // Software writes; sticky status is write-one-to-clear
      if (apb_wr && paddr == EVENT_STATUS_OFS) begin
         next_cur.status = cur.status & ~pwdata[EV_COUNT-1:0];
      end
      if (apb_wr && paddr == EVENT_MASK_OFS) begin
         next_cur.mask = pwdata[EV_COUNT-1:0];
      end
      if (apb_wr && paddr == STANDBY_CTRL_OFS) begin
         next_cur.standby_control_reg = pwdata[0];
      end
      // New events win over a clear in the same cycle
      next_cur.status = next_cur.status | ev;

      // Read data captured in setup so it comes from a flop
      if (apb_setup && !pwrite) begin
         case (paddr)
            EVENT_STATUS_OFS: next_cur.rdata = {28'h0000000, cur.status};
            EVENT_MASK_OFS: next_cur.rdata = {28'h0000000, cur.mask};
            STANDBY_CTRL_OFS: next_cur.rdata = {31'h00000000, cur.standby_control_reg};
            CORE_STATE_OFS: next_cur.rdata = {30'h00000000, cur.standby_latched,
                                              cur.mode == POWER_DOWN};
            default: next_cur.rdata = 32'h0000_0000;
         endcase
      end
   end

   // All state in one register; internal state simply holds in power-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur.mode <= RUNNING;
         cur.standby_latched <= 1'b0;
         cur.res <= '0;
         cur.status <= '0;
         cur.mask <= EVENT_MASK_RST;
         cur.standby_control_reg <= STANDBY_CTRL_RST;
         cur.rdata <= 32'h0000_0000;
      end else begin
         cur <= next_cur;
      end
   end

   assign result = cur.res;
   assign prdata = cur.rdata;
   // RQ4 power-down level for the clock controller
   assign power_down = (cur.mode == POWER_DOWN);
   assign standby = cur.standby_latched;
   assign irq = |(cur.status & cur.mask);
endmodule

`default_nettype wire

// [bench/exec_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module exec_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire exec_pkg::decode_req_t instr,
   input wire logic instr_ready,
   input wire logic [31:0] dest_gpr_value,
   input wire logic irq_request,
   input wire exec_pkg::exec_result_t result,
   input wire logic power_down
);
   import exec_pkg::*;
   logic tk;
   // Request accepted at this edge
   assign tk = instr.valid && instr_ready;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_slp;
      tk && instr.opcode == 16'h001B;
   endsequence
   sequence s_op(logic [3:0] hi, logic [7:0] lo);
      tk && instr.opcode[15:12] == hi && instr.opcode[7:0] == lo;
   endsequence
   property p_halt;
      power_down |-> !instr_ready;
   endproperty
   a_halt: assert property (p_halt) else $error("issue in power-down");
   property p_sleep;
      s_slp ##0 (instr.privileged && !instr.in_delay_slot) |=> power_down && !result.illegal;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no power-down");
   property p_user;
      s_slp ##0 (!instr.privileged && !instr.in_delay_slot) |=> result.illegal && !power_down;
   endproperty
   a_user: assert property (p_user) else $error("user sleep not refused");
   property p_slot;
      s_slp ##0 instr.in_delay_slot |=> result.slot_illegal && !power_down;
   endproperty
   a_slot: assert property (p_slot) else $error("slot sleep not refused");
   property p_wake;
      power_down && irq_request |=> !power_down && result.pc_advance;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   // Shift keeps the upper two bits clear
   property p_shr;
      s_op(4'h4, 8'h09) |=> result.gpr_we && result.gpr_data == $past(dest_gpr_value) >> 2;
   endproperty
   a_shr: assert property (p_shr) else $error("bad shift by two");
   property p_push;
      s_op(4'h4, 8'h13) |=> result.mem_we && result.mem_addr == $past(dest_gpr_value) - 32'h4;
   endproperty
   a_push: assert property (p_push) else $error("bad push address");
   property p_priv;
      s_op(4'h0, 8'h22) ##0 !instr.privileged |=> result.illegal && !result.gpr_we;
   endproperty
   a_priv: assert property (p_priv) else $error("user copy not refused");
endmodule
bind shift_sleep_ctrlreg_store_exec exec_assertions u_exec_assertions (
   .pclk(pclk), .presetn(presetn), .instr(instr), .instr_ready(instr_ready),
   .dest_gpr_value(dest_gpr_value), .irq_request(irq_request), .result(result),
   .power_down(power_down)
);
`default_nettype wire

// [bench/cpu_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
   input wire logic pclk,
   input wire logic [3:0] dest_gpr_rd_idx,
   output logic [31:0] dest_gpr_value,
   input wire exec_pkg::bank_sel_t banked_sel,
   output logic [31:0] banked_gpr,
   input wire exec_pkg::exec_result_t result
);
   import exec_pkg::*;
   logic [31:0] gpr [16];
   // Register file read follows the index with no delay
   assign dest_gpr_value = gpr[dest_gpr_rd_idx];
   // Bank and index are encoded in the value so a wrong pick shows
   assign banked_gpr = {7'h58, banked_sel.bank, 21'h0, banked_sel.index};
   // Write-back on the pulse; memory writes are judged on the result itself
   initial begin
      for (int i = 0; i < 16; i++) begin
         gpr[i] = {i[3:0], 28'h2345678};
      end
      forever begin
         @(posedge pclk);
         if (result.gpr_we) begin
            gpr[result.gpr_idx] <= result.gpr_data;
         end
      end
   end
endmodule
`default_nettype wire

// [bench/shift_sleep_ctrlreg_store_exec_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module shift_sleep_ctrlreg_store_exec_tb_top;
   import exec_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_ready, err;
   logic bank_select_bit, irq_request, power_down, standby, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, dest_gpr_value, banked_gpr, rd, old, bv;
   logic [3:0] dest_gpr_rd_idx;
   logic [7:0] cp [6] = '{8'h12, 8'h22, 8'h32, 8'h42, 8'h3A, 8'hFA};
   logic [7:0] pu [6] = '{8'h13, 8'h23, 8'h33, 8'h43, 8'h32, 8'hF2};
   int sh [3] = '{2, 8, 16};
   decode_req_t instr;
   ctrl_regs_t ctrl_regs;
   bank_sel_t banked_sel;
   exec_result_t result, res;
   int miscompares, checked;
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   shift_sleep_ctrlreg_store_exec u_shift_sleep_ctrlreg_store_exec (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
      .instr_ready(instr_ready), .dest_gpr_value(dest_gpr_value),
      .dest_gpr_rd_idx(dest_gpr_rd_idx), .ctrl_regs(ctrl_regs),
      .bank_select_bit(bank_select_bit), .banked_sel(banked_sel), .banked_gpr(banked_gpr),
      .irq_request(irq_request), .result(result), .power_down(power_down),
      .standby(standby), .irq(irq));
   cpu_side_model u_cpu_side_model (.pclk(pclk), .dest_gpr_rd_idx(dest_gpr_rd_idx),
      .dest_gpr_value(dest_gpr_value), .banked_sel(banked_sel), .banked_gpr(banked_gpr),
      .result(result));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s exp %h got %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bus cycle; the request holds until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) begin
            miscompares++;
            print_verdict();
         end
      end while (pready !== 1'b1);
      // Answer taken at the same edge that ends the access
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // One instruction; result is captured, then write-back lands
   task automatic issue(input logic [15:0] op, input logic pr, input logic sl);
      @(posedge pclk);
      instr <= {1'b1, op, sl, pr};
      @(posedge pclk);
      instr.valid <= 1'b0;
      @(negedge pclk);
      res = result;
      @(negedge pclk);
   endtask
   initial begin
      {instr, psel, penable, pwrite, paddr, pwdata, irq_request, bank_select_bit} = '0;
      {presetn, miscompares, checked} = '0;
      ctrl_regs = {32'hC0000001, 32'hC0000002, 32'hC0000003, 32'hC0000004, 32'hC0000005,
         32'hC0000006};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h004, 0);
      chk("mask", 0, rd);
      for (int k = 0; k < 3; k++) begin
         old = u_cpu_side_model.gpr[1];
         issue({8'h41, 2'b00, k[1:0], 4'h9}, 1, 0);
         chk("shift", old >> sh[k], res.gpr_data);
         chk("pc", 1, res.pc_advance);
         chk("idx", 1, res.gpr_idx);
      end
      for (int k = 0; k < 6; k++) begin
         bv = ctrl_regs[191 - 32 * k -: 32];
         issue({8'h03, cp[k]}, 1, 0);
         chk("copy", {1'b1, bv}, {res.gpr_we, res.gpr_data});
         old = u_cpu_side_model.gpr[3];
         issue({8'h43, pu[k]}, 1, 0);
         chk("push", bv, res.mem_data);
         chk("addr", old - 4, res.mem_addr);
         chk("dec", old - 4, res.gpr_data);
      end
      for (int m = 0; m < 16; m++) begin
         @(posedge pclk);
         bank_select_bit <= m[3];
         bv = {7'h58, ~m[3], 21'h0, m[2:0]};
         issue({8'h02, 1'b1, m[2:0], 4'h2}, 1, 0);
         chk("bank", bv, res.gpr_data);
         issue({8'h42, 1'b1, m[2:0], 4'h3}, 1, 0);
         chk("bankpush", bv, res.mem_data);
      end
      issue(16'h0322, 0, 0);
      chk("user", 2'b10, {res.illegal, res.gpr_we});
      issue(16'h0312, 0, 0);
      chk("userok", 2'b01, {res.illegal, res.gpr_we});
      for (int b = 0; b < 2; b++) begin
         apb(1, 12'h008, b);
         issue(16'h001B, 1, 0);
         chk("pd", {2'b10, b[0]}, {power_down, instr_ready, standby});
         apb(0, 12'h00C, 0);
         chk("state", {b[0], 1'b1}, rd);
         @(posedge pclk);
         irq_request <= 1'b1;
         @(posedge pclk);
         irq_request <= 1'b0;
         @(negedge pclk);
         chk("wake", 2'b01, {power_down, result.pc_advance});
      end
      issue(16'h001B, 0, 0);
      chk("usleep", 2'b10, {res.illegal, power_down});
      issue(16'h001B, 1, 1);
      chk("slot", 2'b10, {res.slot_illegal, power_down});
      apb(0, 12'h000, 0);
      chk("status", 4'hF, rd);
      chk("irqmask", 0, irq);
      apb(1, 12'h004, 32'h0000000F);
      @(negedge pclk);
      chk("irq", 1, irq);
      apb(1, 12'h000, 32'h0000000F);
      @(negedge pclk);
      chk("irqclr", 0, irq);
      apb(0, 12'h010, 0);
      chk("unmapped", 1, err);
      print_verdict();
   end
endmodule
`default_nettype wire
